// ===== verilog/tfsi_top.sv
`include "tfsi_cfg.svh"

// Operation
// - With flush input enable set and formatter running, flushin rising edge starts a flush.
// - Trigger insertion marks a trigger with data byte 0x00 on source id 0x7D.
// - Trigger insert and formatter enable bits change only in Disabled state.
// - Formatting active if formatter enable, trigger insert, or not circular buffer mode.
// - Sync period exponent is bits 4:0, resets to 10, sets reload.
// - A new reload value takes effect only at the next zero.
// - While capture is enabled the counter counts stored trace bytes.
// - Counter reaching zero raises a sync request on the trace slave port.
// - Exponent 0 disables, 7 to 27 give 2^n bytes, others reserved.
// - A reserved exponent write becomes 27, used and read back.
// - Reading the sync register returns the exponent, not the live count.
// - Frame sync embed, sync enabled and formatting active insert frame sync at zero.
// - Outside integration mode test registers read zero and ignore writes.
// - Event test register bits 3:0 drive bufintr, flushcomp, full, acqcomp.
// - Capture bits latch rising edges of flushin (bit 1) and trigin (bit 0).
// - Capture bits clear on read and when integration mode is left.
// - Data capture returns atdata_s bit 0, then bits 7,15..127.
// - Trace output test bits 2:0 drive syncreq_s, afvalid_s, atready_s.
// - Integration mode is on while its control bit 0 is set.
// - Flush start raises afvalid_s until the source answers with afready_s.
module tfsi_top
  import tfsi_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [11:0]  awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [11:0]  araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  input  wire logic         ctrl_disabled,
  input  wire logic         capture_enable,
  input  wire logic         circular_buffer_mode,
  input  wire logic         formatter_stopped,
  input  wire logic [4:0]   bytes_stored,
  input  wire logic         trigger_event,
  input  wire logic         store_ready,
  input  wire logic         bufintr_func,
  input  wire logic         flushcomp_func,
  input  wire logic         full_func,
  input  wire logic         acqcomp_func,
  input  wire logic         flushin,
  input  wire logic         trigin,
  input  wire logic [127:0] atdata_s,
  input  wire logic         afready_s,
  output logic              atready_s,
  output logic              afvalid_s,
  output logic              syncreq_s,
  output logic              flush_start,
  output logic              formatting_active,
  output logic              trig_insert_valid,
  output logic [7:0]        trig_insert_data,
  output logic [6:0]        trig_insert_id,
  output logic              frame_sync_insert,
  output logic              bufintr,
  output logic              flushcomp,
  output logic              full,
  output logic              acqcomp
);

  // ==========================================
  // Decode helpers
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `TFSI_OFF_FMT) || (a == `TFSI_OFF_SYNC) || (a == `TFSI_OFF_ITEVT) ||
                (a == `TFSI_OFF_ITCAP) || (a == `TFSI_OFF_ITDAT) || (a == `TFSI_OFF_ITOUT) ||
                (a == `TFSI_OFF_ITCTL);
  endfunction

  function automatic logic is_test(input logic [11:0] a);
    is_test = (a == `TFSI_OFF_ITEVT) || (a == `TFSI_OFF_ITCAP) || (a == `TFSI_OFF_ITDAT) ||
              (a == `TFSI_OFF_ITOUT);
  endfunction

  // Reserved codes fold to the largest legal exponent
  function automatic tfsi_exp_t exp_norm(input tfsi_exp_t v);
    if (v == 5'h00 || (v >= `TFSI_EXP_MIN && v <= `TFSI_EXP_MAX))
      exp_norm = v;
    else
      exp_norm = `TFSI_EXP_MAX;
  endfunction

  logic        aw_q;
  logic        w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  tfsi_resp_t  bresp_q;
  logic        rvalid_q;
  tfsi_resp_t  rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wr_go;
  logic        wr_en;
  logic        rd_go;
  logic        flin_q;
  logic        trig_ins_q;
  logic        fmt_en_q;
  logic        emb_q;
  tfsi_exp_t   exp_q;
  logic        itm_q;
  logic [3:0]  it_evt_q;
  logic [2:0]  it_out_q;
  logic [1:0]  cap_q;
  logic [16:0] dat_sel;
  logic [2:0]  fl_sync_q;
  logic [2:0]  tr_sync_q;
  logic        fl_rise;
  logic        tr_rise;
  logic        flush_start_q;
  logic        afvalid_q;
  logic [`TFSI_CNT_W-1:0] cnt_q;
  logic [`TFSI_CNT_W-1:0] bytes_w;
  logic [`TFSI_CNT_W-1:0] reload;
  logic        counting;
  logic        sync_zero;
  logic        sync_hit_q;
  logic        fsync_q;
  logic        trig_q;

  // ==========================================
  // AXI4-Lite write channel
  // Address and data are parked independently; the write lands once both are held
  assign awready = !aw_q;
  assign wready  = !w_q;
  assign wr_go   = aw_q && w_q && !bvalid_q;
  assign wr_en   = wr_go && wstrb_q[0] && is_mapped(awaddr_q);
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= TFSI_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= awaddr;
      end
      else if (wr_go)
        aw_q <= 1'b0;
      if (wvalid && wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      else if (wr_go)
        w_q <= 1'b0;
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= is_mapped(awaddr_q) ? TFSI_OKAY : TFSI_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  assign arready = !rvalid_q;
  assign rd_go   = arvalid && arready;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  // Sample bit 0 and the top bit of every byte lane
  assign dat_sel[0] = atdata_s[0];
  for (genvar g = 1; g <= 16; g++)
  begin : g_dat
    assign dat_sel[g] = atdata_s[8*g-1];
  end

  // Read mux; test registers stay dark outside integration mode
  always_comb
  begin
    rdata_d = 32'h00000000;
    unique case (araddr)
      `TFSI_OFF_FMT: rdata_d = {27'h0000000, flin_q, 2'h0, trig_ins_q, fmt_en_q};
      `TFSI_OFF_SYNC: rdata_d = {26'h0000000, emb_q, exp_q};
      `TFSI_OFF_ITCAP: rdata_d = itm_q ? {30'h00000000, cap_q} : 32'h00000000;
      `TFSI_OFF_ITDAT: rdata_d = itm_q ? {15'h0000, dat_sel} : 32'h00000000;
      `TFSI_OFF_ITCTL: rdata_d = {31'h00000000, itm_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= TFSI_OKAY;
      rdata_q  <= 32'h00000000;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= is_mapped(araddr) ? TFSI_OKAY : TFSI_SLVERR;
      rdata_q  <= rdata_d;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // ==========================================
  // Formatter and flush control
  // Trigger insert and formatter enable bits are frozen outside Disabled so the running frame format cannot change
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flin_q     <= 1'b0;
      trig_ins_q <= 1'b0;
      fmt_en_q   <= 1'b0;
    end
    else if (wr_en && awaddr_q == `TFSI_OFF_FMT)
    begin
      flin_q <= wdata_q[`TFSI_FMT_FLIN];
      if (ctrl_disabled)
      begin
        trig_ins_q <= wdata_q[`TFSI_FMT_TRIG];
        fmt_en_q   <= wdata_q[`TFSI_FMT_EN];
      end
    end
  end

  assign formatting_active = fmt_en_q || trig_ins_q || !circular_buffer_mode;

  // ==========================================
  // Sync period register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      emb_q <= 1'b0;
      exp_q <= `TFSI_EXP_RST;
    end
    else if (wr_en && awaddr_q == `TFSI_OFF_SYNC)
    begin
      emb_q <= wdata_q[`TFSI_SYNC_EMB];
      exp_q <= exp_norm(wdata_q[4:0]);
    end
  end

  // ==========================================
  // Integration control and drive registers
  // Drive values are dropped on leaving integration mode so stale pins never return
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      itm_q    <= 1'b0;
      it_evt_q <= 4'h0;
      it_out_q <= 3'h0;
    end
    else
    begin
      if (wr_en && awaddr_q == `TFSI_OFF_ITCTL)
        itm_q <= wdata_q[0];
      if (!itm_q)
      begin
        it_evt_q <= 4'h0;
        it_out_q <= 3'h0;
      end
      else if (wr_en && awaddr_q == `TFSI_OFF_ITEVT)
        it_evt_q <= wdata_q[3:0];
      else if (wr_en && awaddr_q == `TFSI_OFF_ITOUT)
        it_out_q <= wdata_q[2:0];
    end
  end

  // ==========================================
  // Pin synchronisers; edges are taken from the second and third stages only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fl_sync_q <= 3'h0;
      tr_sync_q <= 3'h0;
    end
    else
    begin
      fl_sync_q <= {fl_sync_q[1:0], flushin};
      tr_sync_q <= {tr_sync_q[1:0], trigin};
    end
  end

  assign fl_rise = fl_sync_q[1] && !fl_sync_q[2];
  assign tr_rise = tr_sync_q[1] && !tr_sync_q[2];

  // Capture bits: a new edge wins over the clear by read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cap_q <= 2'h0;
    else if (!itm_q)
      cap_q <= 2'h0;
    else
    begin
      if (fl_rise)
        cap_q[1] <= 1'b1;
      else if (rd_go && araddr == `TFSI_OFF_ITCAP)
        cap_q[1] <= 1'b0;
      if (tr_rise)
        cap_q[0] <= 1'b1;
      else if (rd_go && araddr == `TFSI_OFF_ITCAP)
        cap_q[0] <= 1'b0;
    end
  end

  // ==========================================
  // Flush request toward the trace source
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flush_start_q <= 1'b0;
      afvalid_q     <= 1'b0;
    end
    else
    begin
      flush_start_q <= flin_q && !formatter_stopped && fl_rise;
      if (flin_q && !formatter_stopped && fl_rise)
        afvalid_q <= 1'b1;
      else if (afready_s)
        afvalid_q <= 1'b0;
    end
  end

  assign flush_start = flush_start_q;

  // ==========================================
  // Periodic sync counter
  // Reload is read from the exponent only at zero, so rewrites never cut a period short
  assign bytes_w   = {23'h000000, bytes_stored};
  assign reload    = `TFSI_CNT_W'(1) << exp_q;
  assign counting  = capture_enable && (exp_q != 5'h00);
  assign sync_zero = counting && (bytes_w != '0) && (bytes_w >= cnt_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q      <= `TFSI_CNT_RST;
      sync_hit_q <= 1'b0;
      fsync_q    <= 1'b0;
    end
    else
    begin
      sync_hit_q <= sync_zero;
      fsync_q    <= sync_zero && emb_q && formatting_active;
      if (sync_zero)
        cnt_q <= reload;
      else if (counting)
        cnt_q <= cnt_q - bytes_w;
    end
  end

  assign frame_sync_insert = fsync_q;

  // ==========================================
  // Trigger marker
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trig_q <= 1'b0;
    else
      trig_q <= trigger_event && trig_ins_q;
  end

  assign trig_insert_valid = trig_q;
  assign trig_insert_data  = `TFSI_TRIG_DATA;
  assign trig_insert_id    = `TFSI_TRIG_ID;

  // ==========================================
  // Output steering between functional and integration sources
  assign bufintr   = itm_q ? it_evt_q[3] : bufintr_func;
  assign flushcomp = itm_q ? it_evt_q[2] : flushcomp_func;
  assign full      = itm_q ? it_evt_q[1] : full_func;
  assign acqcomp   = itm_q ? it_evt_q[0] : acqcomp_func;
  assign syncreq_s = itm_q ? it_out_q[2] : sync_hit_q;
  assign afvalid_s = itm_q ? it_out_q[1] : afvalid_q;
  assign atready_s = itm_q ? it_out_q[0] : store_ready;

  // ==========================================
  // Checks
  property p_flush_start;
    @(posedge aclk) disable iff (!aresetn)
    (flin_q && !formatter_stopped && fl_rise) |=> (flush_start && afvalid_q);
  endproperty
  a_flush_start: assert property (p_flush_start) else $error("flush not started");

  property p_af_hold;
    @(posedge aclk) disable iff (!aresetn)
    (afvalid_q && !afready_s) |=> afvalid_q;
  endproperty
  a_af_hold: assert property (p_af_hold) else $error("afvalid dropped early");

  property p_lock;
    @(posedge aclk) disable iff (!aresetn)
    !ctrl_disabled |=> $stable({trig_ins_q, fmt_en_q});
  endproperty
  a_lock: assert property (p_lock) else $error("enable bit changed while running");

  property p_exp_legal;
    @(posedge aclk) disable iff (!aresetn)
    (exp_q == 5'h00) || (exp_q >= 5'h07 && exp_q <= 5'h1B);
  endproperty
  a_exp_legal: assert property (p_exp_legal) else $error("reserved exponent held");

  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
    sync_zero |=> (cnt_q == $past(reload)) && (sync_hit_q == 1'b1);
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_test_zero;
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && !itm_q && is_test(araddr)) |=> (rdata == 32'h00000000);
  endproperty
  a_test_zero: assert property (p_test_zero) else $error("test register read nonzero");

  property p_cap_clear;
    @(posedge aclk) disable iff (!aresetn)
    !itm_q |=> (cap_q == 2'h0);
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture kept outside test mode");

  property p_trig;
    @(posedge aclk) disable iff (!aresetn)
    (trigger_event && trig_ins_q) |=> trig_insert_valid && (trig_insert_id == 7'h7D);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger marker missing");

  property p_evt_drive;
    @(posedge aclk) disable iff (!aresetn)
    itm_q |-> ({bufintr, flushcomp, full, acqcomp} == it_evt_q);
  endproperty
  a_evt_drive: assert property (p_evt_drive) else $error("event pins not driven");

endmodule

// ===== verilog/tfsi_cfg.svh
`ifndef TFSI_CFG_SVH
`define TFSI_CFG_SVH
// ==========================================
// Register offsets (byte addresses)
`define TFSI_OFF_FMT   12'h304
`define TFSI_OFF_SYNC  12'h308
`define TFSI_OFF_ITEVT 12'hEE0
`define TFSI_OFF_ITCAP 12'hEE8
`define TFSI_OFF_ITDAT 12'hEEC
`define TFSI_OFF_ITOUT 12'hEF0
`define TFSI_OFF_ITCTL 12'hF00
// ==========================================
// Field positions and reset values
`define TFSI_FMT_FLIN  4
`define TFSI_FMT_TRIG  1
`define TFSI_FMT_EN    0
`define TFSI_SYNC_EMB  5
`define TFSI_EXP_RST   5'h0A
`define TFSI_EXP_MIN   5'h07
`define TFSI_EXP_MAX   5'h1B
`define TFSI_CNT_RST   28'h0000400
// ==========================================
// Trigger marker and widths
`define TFSI_TRIG_DATA 8'h00
`define TFSI_TRIG_ID   7'h7D
`define TFSI_CNT_W     28
`define TFSI_ATB_W     128
`endif

// ===== verilog/tfsi_pkg.sv
package tfsi_pkg;
  // ==========================================
  // Shared types
  typedef logic [4:0] tfsi_exp_t;
  typedef enum logic [1:0]
  {
    TFSI_OKAY   = 2'h0,
    TFSI_SLVERR = 2'h2
  } tfsi_resp_t;
endpackage

// ===== tb/tfsi_source.sv
// ==========================================
// Trace source model: answers flush requests after a set delay
module tfsi_source
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       afvalid_s,
  input  wire logic [3:0] ack_delay,
  output logic            afready_s
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  // One-cycle acknowledge, only after the request has been seen for ack_delay cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      afready_s <= 1'b0;
      wait_q    <= 4'h0;
    end
    else if (afready_s || !afvalid_s)
    begin
      afready_s <= 1'b0;
      wait_q    <= 4'h0;
    end
    else if (wait_q == ack_delay)
      afready_s <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule

// ===== tb/tfsi_bench.sv
`include "tfsi_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tfsi_bench import tfsi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Stimulus and observed signals
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = '0, ack_delay = 4'h1;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, afready_s, atready_s, afvalid_s, syncreq_s;
  logic flush_start, formatting_active, trig_insert_valid, frame_sync_insert, bufintr, flushcomp, full, acqcomp;
  logic ctrl_disabled = 0, capture_enable = 0, circular_buffer_mode = 0, formatter_stopped = 0;
  logic trigger_event = 0, store_ready = 0, flushin = 0, trigin = 0;
  logic bufintr_func = 0, flushcomp_func = 0, full_func = 0, acqcomp_func = 0;
  logic [4:0] bytes_stored = '0;
  logic [127:0] atdata_s = '0;
  logic [7:0] trig_insert_data;
  logic [6:0] trig_insert_id;
  logic [15:0] seed = 16'h0054;
  int err_total = 0, n_compared = 0, n_sync = 0, n_fsync = 0, n_flush = 0, base;

  tfsi_top tfsi_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ctrl_disabled, .capture_enable,
    .circular_buffer_mode, .formatter_stopped, .bytes_stored, .trigger_event, .store_ready, .bufintr_func,
    .flushcomp_func, .full_func, .acqcomp_func, .flushin, .trigin, .atdata_s, .afready_s, .atready_s, .afvalid_s,
    .syncreq_s, .flush_start, .formatting_active, .trig_insert_valid, .trig_insert_data, .trig_insert_id,
    .frame_sync_insert, .bufintr, .flushcomp, .full, .acqcomp);
  tfsi_source tfsi_source_i (.aclk, .aresetn, .afvalid_s, .ack_delay, .afready_s);

  always #2 aclk = ~aclk;

  // Pulse counters sample what the design presented at each edge
  always @(posedge aclk)
  begin
    n_sync  <= n_sync + int'(syncreq_s);
    n_fsync <= n_fsync + int'(frame_sync_insert);
    n_flush <= n_flush + int'(flush_start);
  end

  // ==========================================
  // Expectation helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Reserved exponents fold to the largest legal one
  function automatic logic [4:0] exp_fix(input logic [4:0] x);
    return (x == 5'h00 || (x >= 5'h07 && x <= 5'h1B)) ? x : 5'h1B;
  endfunction
  function automatic logic [31:0] pick_bits(input logic [127:0] d);
    logic [31:0] r;
    r = {31'h0, d[0]};
    for (int i = 1; i <= 16; i++)
      r[i] = d[8 * i - 1];
    return r;
  endfunction

  // ==========================================
  // Bus tasks: entered and left just after a rising edge; handshakes sampled at the rising edge
  // bready and rready stay high once raised; each call sets them high again and nothing lowers them
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic a_ok, w_ok, b_ok;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      a_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      rs = bresp;
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!b_ok);
  endtask
  task automatic rdr(input logic [11:0] a);
    logic a_ok, r_ok;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      a_ok = arvalid && arready;
      r_ok = rvalid;
      rd = rdata;
      rs = rresp;
      if (a_ok) arvalid <= 1'b0;
    end while (!r_ok);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Waits for afvalid_s to reach a level, bounded
  task automatic wait_af(input logic lvl);
    for (int i = 0; i < 40 && afvalid_s !== lvl; i++)
      @(posedge aclk);
  endtask

  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    cycles(20000);
    err_total++;
    close_out();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    cycles(12);
    aresetn <= 1'b1;
    cycles(1);
    rdr(`TFSI_OFF_SYNC);
    `CHK(rd, 32'h0000000A)
    // Exponent encodings, fixed values 7, 0, 7, 24, 16, 15 then random values
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      rd = (i < 6) ? {27'h0, 5'(32'h1F0C1C07 >> (5 * i))} : {26'h0, seed[5:0]};
      wr(`TFSI_OFF_SYNC, rd);
      rdr(`TFSI_OFF_SYNC);
      `CHK(rd, {26'h0, wdata[5], exp_fix(wdata[4:0])})
    end
    // Counter keeps the 1024 in progress, then reloads at 128 bytes
    wr(`TFSI_OFF_SYNC, 32'h00000027);
    base = n_sync;
    capture_enable <= 1'b1;
    bytes_stored <= 5'h10;
    cycles(88);
    capture_enable <= 1'b0;
    cycles(30);
    @(negedge aclk);
    `CHK(n_sync - base, 4)
    `CHK(n_fsync, 4)
    @(posedge aclk);
    rdr(`TFSI_OFF_SYNC);
    `CHK(rd, 32'h00000027)
    // Formatter bits locked outside the Disabled state
    circular_buffer_mode <= 1'b1;
    wr(`TFSI_OFF_FMT, 32'h00000013);
    rdr(`TFSI_OFF_FMT);
    `CHK(rd, 32'h00000010)
    `CHK(formatting_active, 1'b0)
    ctrl_disabled <= 1'b1;
    wr(`TFSI_OFF_FMT, 32'h00000012);
    `CHK(formatting_active, 1'b1)
    trigger_event <= 1'b1;
    @(posedge aclk);
    trigger_event <= 1'b0;
    @(negedge aclk);
    `CHK({trig_insert_valid, trig_insert_data, trig_insert_id}, {1'b1, 8'h00, 7'h7D})
    // Flush on flushin, slow acknowledge
    ack_delay <= 4'h6;
    base = n_flush;
    flushin <= 1'b1;
    wait_af(1'b1);
    wait_af(1'b0);
    flushin <= 1'b0;
    `CHK(afvalid_s, 1'b0)
    `CHK(n_flush - base, 1)
    formatter_stopped <= 1'b1;
    cycles(2);
    flushin <= 1'b1;
    cycles(10);
    `CHK(n_flush - base, 1)
    flushin <= 1'b0;
    // Test registers inert outside integration mode
    {bufintr_func, flushcomp_func, full_func, acqcomp_func} <= 4'h5;
    wr(`TFSI_OFF_ITEVT, 32'h0000000F);
    @(negedge aclk);
    `CHK({bufintr, flushcomp, full, acqcomp}, 4'h5)
    @(posedge aclk);
    rdr(`TFSI_OFF_ITDAT);
    `CHK(rd, 32'h00000000)
    // Integration mode drives and captures
    wr(`TFSI_OFF_ITCTL, 32'h00000001);
    wr(`TFSI_OFF_ITEVT, 32'h0000000A);
    wr(`TFSI_OFF_ITOUT, 32'h00000005);
    @(negedge aclk);
    `CHK({bufintr, flushcomp, full, acqcomp}, 4'hA)
    `CHK({syncreq_s, afvalid_s, atready_s}, 3'h5)
    @(posedge aclk);
    rdr(`TFSI_OFF_ITEVT);
    `CHK(rd, 32'h00000000)
    rdr(`TFSI_OFF_ITOUT);
    `CHK(rd, 32'h00000000)
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      atdata_s <= {4{seed, ~seed}} ^ {128{seed[i]}};
      cycles(1);
      rdr(`TFSI_OFF_ITDAT);
      `CHK(rd, pick_bits(atdata_s))
    end
    trigin <= 1'b1;
    flushin <= 1'b1;
    cycles(6);
    rdr(`TFSI_OFF_ITCAP);
    `CHK(rd, 32'h00000003)
    rdr(`TFSI_OFF_ITCAP);
    `CHK(rd, 32'h00000000)
    trigin <= 1'b0;
    cycles(3);
    trigin <= 1'b1;
    cycles(6);
    wr(`TFSI_OFF_ITCTL, 32'h00000000);
    wr(`TFSI_OFF_ITCTL, 32'h00000001);
    rdr(`TFSI_OFF_ITCAP);
    `CHK(rd, 32'h00000000)
    rdr(`TFSI_OFF_ITCTL);
    `CHK(rd, 32'h00000001)
    // Unmapped address answers with an error
    rdr(12'h100);
    `CHK(rs, TFSI_SLVERR)
    wr(12'h100, 32'h00000001);
    `CHK(rs, TFSI_SLVERR)
    close_out();
  end
endmodule
